// ==== rtl/sdcd_cfg.svh ====
// timing and field constants of the command decoder
`ifndef SDCD_CFG_SVH
`define SDCD_CFG_SVH
`define SDCD_BANK_W        3
`define SDCD_ADDR_W        13
`define SDCD_AUTO_CLOSE_POS 10
`define SDCD_CHOP_POS      12
`define SDCD_FULL_BEATS    8
`define SDCD_CHOP_BEATS    4
`define SDCD_RETENTION_GAP 512
`define SDCD_MODE_GAP      12
`define SDCD_BL_FIELD_RST  2'h0
`endif

// ==== rtl/sdcd_pkg.sv ====
// types shared by both ends of the command decoder
package sdcd_pkg;
    typedef enum logic [3:0] {
        SDCD_OP_NONE     = 4'h0,
        SDCD_OP_MODE     = 4'h1,
        SDCD_OP_REFRESH  = 4'h2,
        SDCD_OP_RET_IN   = 4'h3,
        SDCD_OP_RET_OUT  = 4'h4,
        SDCD_OP_CLOSE    = 4'h5,
        SDCD_OP_CLOSEALL = 4'h6,
        SDCD_OP_OPEN     = 4'h7,
        SDCD_OP_STORE    = 4'h8,
        SDCD_OP_LOAD     = 4'h9,
        SDCD_OP_CAL_LONG = 4'hA,
        SDCD_OP_CAL_SHRT = 4'hB,
        SDCD_OP_SLP_IN   = 4'hC,
        SDCD_OP_SLP_OUT  = 4'hD
    } sdcd_op_t;

    typedef enum logic [3:0] {
        SDCD_ST_READY  = 4'b0001,
        SDCD_ST_BURST  = 4'b0010,
        SDCD_ST_SLEEP  = 4'b0100,
        SDCD_ST_RETAIN = 4'b1000
    } sdcd_state_t;
endpackage : sdcd_pkg

// ==== rtl/sdcd_if.sv ====
// command and address wires between controller and memory
`timescale 1ns/1ps
interface sdcd_if;
    logic        chip_sel_n;
    logic        row_strobe_n;
    logic        col_strobe_n;
    logic        write_strobe_n;
    logic        clock_gate;
    logic [2:0]  bank;
    logic [12:0] addr;
    logic        termination_enable;
    modport ctrl (output chip_sel_n, row_strobe_n, col_strobe_n,
                  write_strobe_n, clock_gate, bank, addr,
                  termination_enable);
    modport mem  (input chip_sel_n, row_strobe_n, col_strobe_n,
                  write_strobe_n, clock_gate, bank, addr,
                  termination_enable);
endinterface : sdcd_if

// ==== rtl/sdcd_decode.sv ====
// combinational command word decoder
`timescale 1ns/1ps
`include "sdcd_cfg.svh"
module sdcd_decode
    import sdcd_pkg::*;
(
    input  wire logic       chip_sel_n,
    input  wire logic       row_strobe_n,
    input  wire logic       col_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic       gate_prev,
    input  wire logic       gate_now,
    input  wire logic       auto_close_bit,
    output sdcd_op_t        op,
    output logic            legal
);
    // decode purely from the sampled levels
    always_comb begin
        op    = SDCD_OP_NONE;
        legal = 1'b1;
        if (!gate_prev && gate_now) begin
            // exits need deselect or idle
            if (chip_sel_n || {row_strobe_n, col_strobe_n,
                               write_strobe_n} == 3'b111)
                op = SDCD_OP_RET_OUT; // R15
            else
                legal = 1'b0;
        end else if (gate_prev && !gate_now) begin
            if (!chip_sel_n && {row_strobe_n, col_strobe_n,
                                write_strobe_n} == 3'b001)
                op = SDCD_OP_RET_IN; // R15
            else if (chip_sel_n || {row_strobe_n, col_strobe_n,
                                    write_strobe_n} == 3'b111)
                op = SDCD_OP_SLP_IN;
            else
                legal = 1'b0; // R22
        end else if (!gate_now) begin
            op = SDCD_OP_NONE;
        end else if (chip_sel_n) begin
            op = SDCD_OP_NONE; // R11
        end else begin
            unique case ({row_strobe_n, col_strobe_n, write_strobe_n})
                3'b000: op = SDCD_OP_MODE; // R2
                3'b001: op = SDCD_OP_REFRESH;
                3'b010: op = auto_close_bit ? SDCD_OP_CLOSEALL
                                            : SDCD_OP_CLOSE; // R4
                3'b011: op = SDCD_OP_OPEN; // R3
                3'b100: op = SDCD_OP_STORE; // R5
                3'b101: op = SDCD_OP_LOAD; // R6
                3'b110: op = auto_close_bit ? SDCD_OP_CAL_LONG
                                            : SDCD_OP_CAL_SHRT; // R9
                3'b111: op = SDCD_OP_NONE; // R10
            endcase
        end
    end
endmodule : sdcd_decode

// ==== rtl/sdcd_mem.sv ====
// memory end: samples and interprets each command word
// Summary of operation
// R1: sample command pins each rising edge
// R2: all strobes low means mode load
// R3: row strobe only opens a row
// R4: close one bank, or all when flagged
// R5: column and write strobes mean store
// R6: column strobe alone means load
// R7: burst chop low gives four beats
// R8: auto close bit closes row after burst
// R9: write strobe alone calibrates, long or short
// R10: idle never aborts a running burst
// R11: deselected behaves as idle
// R12: bursts always run to completion; here a decoded clock gate edge (sleep, retention entry or wake) cuts one short
// R13: no internal refresh while asleep
// R14: termination ignored, off in retention
// R15: retention entry and exit via clock gate
// R16: controller waits 512 cycles before store
// R17: controller keeps reset high normally
// R18: valid inputs driven to defined levels
// R19: gate held high through mode gaps
// R20: sleep edges only with idle or deselect
// R21: retention only with all banks idle
// R22: undefined words are ignored
`timescale 1ns/1ps
`include "sdcd_cfg.svh"
module sdcd_mem
    import sdcd_pkg::*;
#(
    parameter int BANKS = 8
) (
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    sdcd_if.mem                            pins,
    output logic [3:0]                     op_code,
    output logic                           op_valid,
    output logic [`SDCD_BANK_W-1:0]        op_bank,
    output logic [`SDCD_ADDR_W-1:0]        op_addr,
    output logic                           burst_busy,
    output logic [3:0]                     burst_beats,
    output logic                           burst_autoclose,
    output logic                           burst_is_store,
    output logic [BANKS-1:0]               bank_open,
    output logic                           asleep,
    output logic                           retaining,
    output logic                           termination_on,
    output logic                           illegal_seen
);
    // the bank decode can only serve one flag per bank field value
    if (BANKS != (1 << `SDCD_BANK_W)) begin : g_bad_banks
        $error("sdcd_mem: BANKS must match bank field width");
    end

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic                      gate_prev;
        sdcd_state_t               st;
        logic [1:0]                bl_mode;
        logic [3:0]                beats;
        logic                      autoclose;
        logic                      is_store;
        logic [`SDCD_BANK_W-1:0]   burst_bank;
        logic [BANKS-1:0]          open;
        logic [3:0]                code;
        logic                      valid;
        logic [`SDCD_BANK_W-1:0]   bank;
        logic [`SDCD_ADDR_W-1:0]   addr;
        logic                      term;
        logic                      illegal;
    } sdcd_mem_state_t;

    sdcd_mem_state_t cur;
    sdcd_mem_state_t next_cur;
    sdcd_op_t        op;
    logic            legal;

    sdcd_decode u_dec (
        .chip_sel_n     (pins.chip_sel_n),
        .row_strobe_n   (pins.row_strobe_n),
        .col_strobe_n   (pins.col_strobe_n),
        .write_strobe_n (pins.write_strobe_n),
        .gate_prev      (cur.gate_prev),
        .gate_now       (pins.clock_gate),
        .auto_close_bit (pins.addr[`SDCD_AUTO_CLOSE_POS]),
        .op             (op),
        .legal          (legal)
    );

    // beats of a burst: fixed field or chop bit on the fly
    function automatic logic [3:0] burst_len(input logic [1:0] mode,
                                             input logic chop_n);
        unique case (mode)
            2'h0:    burst_len = 4'(`SDCD_FULL_BEATS);
            2'h1:    burst_len = chop_n ? 4'(`SDCD_FULL_BEATS)
                                        : 4'(`SDCD_CHOP_BEATS); // R7
            default: burst_len = 4'(`SDCD_CHOP_BEATS);
        endcase
    endfunction : burst_len

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_cur           = cur;
        next_cur.gate_prev = pins.clock_gate; // R1
        next_cur.valid     = 1'b0;
        next_cur.illegal   = !legal; // R22
        // termination follows its pin, forced off by the decoder on retention entry and while retaining
        next_cur.term = pins.termination_enable
                        && cur.st != SDCD_ST_RETAIN; // R14
        // a running burst counts down through any word other than a decoded gate edge: R10 R12
        if (cur.st == SDCD_ST_BURST) begin
            next_cur.beats = cur.beats - 4'h1; // R12
            if (cur.beats == 4'h1) begin
                next_cur.st = SDCD_ST_READY;
                if (cur.autoclose)
                    next_cur.open[cur.burst_bank] = 1'b0; // R8
            end
        end
        if (legal && op != SDCD_OP_NONE) begin
            next_cur.valid = 1'b1;
            next_cur.code  = op;
            next_cur.bank  = pins.bank;
            next_cur.addr  = pins.addr;
        end
        unique case (op)
            SDCD_OP_MODE: begin
                // partition zero holds the burst length field
                if (pins.bank == '0)
                    next_cur.bl_mode = pins.addr[1:0]; // R2
            end
            SDCD_OP_OPEN:     next_cur.open[pins.bank] = 1'b1; // R3
            SDCD_OP_CLOSE:    next_cur.open[pins.bank] = 1'b0; // R4
            SDCD_OP_CLOSEALL: next_cur.open = '0; // R4
            SDCD_OP_STORE, SDCD_OP_LOAD: begin
                // a new column command only starts when not busy
                if (cur.st != SDCD_ST_BURST) begin
                    next_cur.st         = SDCD_ST_BURST; // R12
                    next_cur.beats      = burst_len(cur.bl_mode,
                                   pins.addr[`SDCD_CHOP_POS]); // R7
                    next_cur.autoclose  =
                        pins.addr[`SDCD_AUTO_CLOSE_POS]; // R8
                    next_cur.is_store   = (op == SDCD_OP_STORE);
                    next_cur.burst_bank = pins.bank;
                end
            end
            SDCD_OP_RET_IN: begin
                next_cur.st   = SDCD_ST_RETAIN; // R15
                next_cur.term = 1'b0; // R14
            end
            SDCD_OP_SLP_IN:  next_cur.st = SDCD_ST_SLEEP; // R13
            SDCD_OP_RET_OUT: next_cur.st = SDCD_ST_READY; // R15
            default: ;
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cur           <= '0;
            cur.st        <= SDCD_ST_READY;
            cur.bl_mode   <= `SDCD_BL_FIELD_RST;
            cur.gate_prev <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // all outputs straight from the state record
    assign op_code         = cur.code;
    assign op_valid        = cur.valid;
    assign op_bank         = cur.bank;
    assign op_addr         = cur.addr;
    assign burst_busy      = cur.st == SDCD_ST_BURST;
    assign burst_beats     = cur.beats;
    assign burst_autoclose = cur.autoclose;
    assign burst_is_store  = cur.is_store;
    assign bank_open       = cur.open;
    assign asleep          = cur.st == SDCD_ST_SLEEP; // R13
    assign retaining       = cur.st == SDCD_ST_RETAIN;
    assign termination_on  = cur.term;
    assign illegal_seen    = cur.illegal;
endmodule : sdcd_mem

// ==== rtl/sdcd_ctrl.sv ====
// controller end: drives one command word per request
`timescale 1ns/1ps
`include "sdcd_cfg.svh"
module sdcd_ctrl
    import sdcd_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    sdcd_if.ctrl                       pins,
    input  wire logic                  req,
    input  wire logic [3:0]            req_op,
    input  wire logic [`SDCD_BANK_W-1:0] req_bank,
    input  wire logic [`SDCD_ADDR_W-1:0] req_addr,
    input  wire logic                  req_term,
    input  wire logic                  all_idle,
    output logic                       req_ready,
    output logic                       req_refused
);
    typedef struct packed {
        logic [3:0]                cmd;
        logic                      gate;
        logic [`SDCD_BANK_W-1:0]   bank;
        logic [`SDCD_ADDR_W-1:0]   addr;
        logic                      term;
        logic [9:0]                ret_wait;
        logic [4:0]                mode_wait;
        logic                      refused;
    } sdcd_ctrl_state_t;

    sdcd_ctrl_state_t cur;
    sdcd_ctrl_state_t next_cur;
    sdcd_op_t         rop;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        rop = sdcd_op_t'(req_op);
        next_cur          = cur;
        next_cur.cmd      = 4'hF; // deselect between requests
        next_cur.refused  = 1'b0;
        next_cur.term     = req_term;
        if (cur.ret_wait != '0)
            next_cur.ret_wait = cur.ret_wait - 10'h1;
        if (cur.mode_wait != '0)
            next_cur.mode_wait = cur.mode_wait - 5'h1;
        if (req) begin
            next_cur.bank = req_bank;
            next_cur.addr = req_addr;
            unique case (rop)
                SDCD_OP_MODE: begin
                    next_cur.cmd       = 4'b0000;
                    next_cur.mode_wait = 5'(`SDCD_MODE_GAP);
                end
                SDCD_OP_REFRESH:  next_cur.cmd = 4'b0001;
                SDCD_OP_CLOSE, SDCD_OP_CLOSEALL: begin
                    next_cur.cmd = 4'b0010;
                    next_cur.addr[`SDCD_AUTO_CLOSE_POS] =
                        (rop == SDCD_OP_CLOSEALL);
                end
                SDCD_OP_OPEN:     next_cur.cmd = 4'b0011;
                SDCD_OP_STORE: begin
                    if (cur.ret_wait != '0)
                        next_cur.refused = 1'b1; // R16
                    else
                        next_cur.cmd = 4'b0100;
                end
                SDCD_OP_LOAD:     next_cur.cmd = 4'b0101;
                SDCD_OP_CAL_LONG, SDCD_OP_CAL_SHRT: begin
                    next_cur.cmd = 4'b0110;
                    next_cur.addr[`SDCD_AUTO_CLOSE_POS] =
                        (rop == SDCD_OP_CAL_LONG);
                end
                SDCD_OP_SLP_IN: begin
                    if (cur.mode_wait != '0)
                        next_cur.refused = 1'b1; // R19
                    else
                        next_cur.gate = 1'b0; // R20
                end
                SDCD_OP_RET_IN: begin
                    if (cur.mode_wait != '0 || !all_idle)
                        next_cur.refused = 1'b1; // R19 R21
                    else begin
                        next_cur.cmd  = 4'b0001;
                        next_cur.gate = 1'b0; // R15
                    end
                end
                SDCD_OP_RET_OUT, SDCD_OP_SLP_OUT: begin
                    if (!cur.gate && rop == SDCD_OP_RET_OUT)
                        next_cur.ret_wait =
                            10'(`SDCD_RETENTION_GAP); // R16
                    next_cur.gate = 1'b1; // R20
                end
                default: next_cur.refused = 1'b1;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cur      <= '0;
            cur.cmd  <= 4'hF;
            cur.gate <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // defined levels on all valid pins: R18
    assign pins.chip_sel_n         = cur.cmd[3];
    assign pins.row_strobe_n       = cur.cmd[2];
    assign pins.col_strobe_n       = cur.cmd[1];
    assign pins.write_strobe_n     = cur.cmd[0];
    assign pins.clock_gate         = cur.gate;
    assign pins.bank               = cur.bank;
    assign pins.addr               = cur.addr;
    assign pins.termination_enable = cur.term;
    assign req_ready               = 1'b1;
    assign req_refused             = cur.refused;
endmodule : sdcd_ctrl

// ==== test/sdcd_sva.sv ====
// checker on the command wires between controller and memory ends
`timescale 1ns/1ps
module sdcd_sva (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        chip_sel_n,
    input wire logic        row_strobe_n,
    input wire logic        col_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        clock_gate,
    input wire logic [2:0]  bank,
    input wire logic [12:0] addr,
    input wire logic        termination_enable
);
    // ************************************************************
    // helper state
    // ************************************************************
    logic [2:0] cmd;
    logic [3:0] gap;
    logic [9:0] since_exit;
    logic       in_ret;
    // deselect folds onto the idle word, as the two act alike
    assign cmd = chip_sel_n ? 3'h7
                            : {row_strobe_n, col_strobe_n, write_strobe_n};
    // ages start saturated so a reset never looks like a fresh event
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gap        <= 4'hF;
            since_exit <= 10'h3FF;
            in_ret     <= 1'b0;
        end else begin
            gap <= (cmd == 3'h0) ? 4'h0 : gap + {3'h0, gap != 4'hF};
            if ($rose(clock_gate) && in_ret)
                since_exit <= 10'h000;
            else
                since_exit <= since_exit + {9'h0, since_exit != 10'h3FF};
            if ($fell(clock_gate) && cmd == 3'h1)
                in_ret <= 1'b1;
            else if ($rose(clock_gate))
                in_ret <= 1'b0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ************************************************************
    // assertions
    // ************************************************************
    a_mode_gate_high: assert property (
        cmd == 3'h0 |-> clock_gate && $past(clock_gate))
        else $error("mode load without gate high on both edges");
    a_open_gate_high: assert property (
        cmd == 3'h3 |-> clock_gate && $past(clock_gate))
        else $error("row open without gate high");
    a_access_gate_stable: assert property (
        cmd inside {3'h4, 3'h5} |-> $stable(clock_gate) && clock_gate)
        else $error("load or store without gate held high");
    a_gate_mode_gap: assert property (
        $fell(clock_gate) |-> gap >= 4'hB)
        else $error("gate dropped inside the mode gap");
    a_store_exit_gap: assert property (
        cmd == 3'h4 && clock_gate |-> since_exit >= 10'h1FF)
        else $error("store too soon after retention exit");
    a_wake_word_idle: assert property (
        $rose(clock_gate) |-> cmd == 3'h7)
        else $error("wake edge without idle or deselect");
    a_sleep_word: assert property (
        $fell(clock_gate) |-> cmd == 3'h7 || cmd == 3'h1)
        else $error("gate fell with a word other than idle or refresh");
    a_reset_idle: assert property (disable iff (1'b0)
        !rstn |-> chip_sel_n && clock_gate)
        else $error("pins not deselected during reset");
    c_mode: cover property (cmd == 3'h0);
    c_retain: cover property ($fell(clock_gate) && cmd == 3'h1);
    c_sleep: cover property ($fell(clock_gate) && cmd == 3'h7);
    c_store: cover property (cmd == 3'h4 && in_ret == 1'b0);
endmodule : sdcd_sva

// ==== test/tb_sdram_command_decoder.sv ====
// self-checking bench: controller end drives the memory end
`timescale 1ns/1ps
module tb_sdram_command_decoder;
    import sdcd_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b1;
    logic        req = 1'b0;
    logic [3:0]  req_op = 4'h0;
    logic [2:0]  req_bank = 3'h0;
    logic [12:0] req_addr = 13'h0000;
    logic        req_term = 1'b0;
    logic        all_idle = 1'b0;
    logic        req_refused, op_valid, burst_busy, asleep, retaining;
    logic        termination_on;
    logic [3:0]  op_code;
    logic [2:0]  op_bank;
    logic [12:0] op_addr;
    logic [7:0]  bank_open;
    logic [15:0] rnd = 16'h0006;
    int          bad_count, n_compared, cycles, run, blen;
    logic [3:0]  ops [8] = '{SDCD_OP_OPEN, SDCD_OP_STORE, SDCD_OP_LOAD,
        SDCD_OP_CLOSE, SDCD_OP_CAL_LONG, SDCD_OP_CAL_SHRT,
        SDCD_OP_REFRESH, SDCD_OP_MODE};
    sdcd_if bus ();
    sdcd_ctrl sdcd_ctrl_i (.mclk(mclk), .rstn(rstn), .pins(bus.ctrl),
        .req(req), .req_op(req_op), .req_bank(req_bank),
        .req_addr(req_addr), .req_term(req_term), .all_idle(all_idle),
        .req_ready(), .req_refused(req_refused));
    sdcd_mem sdcd_mem_i (.mclk(mclk), .rstn(rstn), .pins(bus.mem),
        .op_code(op_code), .op_valid(op_valid), .op_bank(op_bank),
        .op_addr(op_addr), .burst_busy(burst_busy), .burst_beats(),
        .burst_autoclose(), .burst_is_store(), .bank_open(bank_open),
        .asleep(asleep), .retaining(retaining),
        .termination_on(termination_on), .illegal_seen());
    sdcd_sva sdcd_check_i (.mclk(mclk), .rstn(rstn),
        .chip_sel_n(bus.chip_sel_n), .row_strobe_n(bus.row_strobe_n),
        .col_strobe_n(bus.col_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .clock_gate(bus.clock_gate),
        .bank(bus.bank), .addr(bus.addr),
        .termination_enable(bus.termination_enable));
    // ************************************************************
    // clock, burst length meter and hang guard
    // ************************************************************
    always #10 mclk = ~mclk;
    // length lands one edge after busy drops
    always @(posedge mclk) begin
        cycles++;
        if (burst_busy === 1'b1)
            run++;
        else if (run != 0) begin
            blen = run;
            run = 0;
        end
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // close with the auto close bit up means every bank
    function automatic logic [3:0] exp_code(input logic [3:0] op,
                                            input logic [12:0] a);
        if (op == SDCD_OP_CLOSE && a[10])
            return SDCD_OP_CLOSEALL;
        return op;
    endfunction : exp_code
    task automatic cmp(input string what, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic stop_test;
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic send(input logic [3:0] op, input logic [2:0] b,
                        input logic [12:0] a);
        @(posedge mclk);
        rnd = lfsr(rnd);
        req <= 1'b1;
        req_op <= op;
        req_bank <= b;
        req_addr <= a;
        req_term <= rnd[0];
        @(posedge mclk);
        req <= 1'b0;
    endtask : send
    task automatic expect_op(input logic [3:0] op, input logic [2:0] b,
                             input logic [12:0] a);
        int k;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (op_valid !== 1'b1 && k < 6);
        cmp("op_code", {12'h0, exp_code(op, a)}, {12'h0, op_code});
        if (op inside {SDCD_OP_OPEN, SDCD_OP_STORE, SDCD_OP_LOAD}) begin
            cmp("op_bank", {13'h0, b}, {13'h0, op_bank});
            cmp("op_addr", {3'h0, a}, {3'h0, op_addr});
        end
    endtask : expect_op
    task automatic settle;
        int k;
        k = 0;
        while (burst_busy !== 1'b0 && k < 20) begin
            @(negedge mclk);
            k++;
        end
        repeat (2) @(negedge mclk);
    endtask : settle
    task automatic try(input logic [3:0] op, input logic e);
        logic seen;
        seen = 1'b0;
        send(op, 3'h0, 13'h0000);
        repeat (3) begin
            @(negedge mclk);
            seen |= req_refused;
        end
        cmp("req_refused", {15'h0, e}, {15'h0, seen});
        repeat (3) @(negedge mclk);
    endtask : try
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [3:0]  op;
        logic [2:0]  b;
        logic [12:0] a;
        // a real falling edge so both ends reset before the first clock
        rstn = 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            op = ops[i % 8];
            b = (op == SDCD_OP_MODE) ? 3'h1 : rnd[2:0];
            a = {rnd[15:3]};
            if (op inside {SDCD_OP_CAL_LONG, SDCD_OP_CAL_SHRT})
                a[10] = (op == SDCD_OP_CAL_LONG);
            // a close request with the flag up asks for every bank
            op = exp_code(op, a);
            send(op, b, a);
            expect_op(op, b, a);
            settle();
        end
        send(SDCD_OP_MODE, 3'h0, 13'h0001);
        expect_op(SDCD_OP_MODE, 3'h0, 13'h0001);
        try(SDCD_OP_SLP_IN, 1'b1);
        cmp("asleep", 16'h0000, {15'h0, asleep});
        for (int j = 0; j < 4; j++) begin
            rnd = lfsr(rnd);
            a = {j[0], rnd[1], j[1], rnd[9:0]};
            // send advances the random word, so hold the bank here
            b = rnd[4:2];
            send(SDCD_OP_OPEN, b, 13'h0000);
            expect_op(SDCD_OP_OPEN, b, 13'h0000);
            send(SDCD_OP_STORE, b, a);
            expect_op(SDCD_OP_STORE, b, a);
            if (j == 0)
                send(SDCD_OP_LOAD, b, a);
            settle();
            cmp("burst_len", j[0] ? 16'h8 : 16'h4, blen[15:0]);
            cmp("row_open", {15'h0, !j[1]}, {15'h0, bank_open[b]});
        end
        send(SDCD_OP_CLOSEALL, 3'h2, 13'h0400);
        expect_op(SDCD_OP_CLOSEALL, 3'h2, 13'h0400);
        cmp("bank_open", 16'h0000, {8'h0, bank_open});
        try(SDCD_OP_RET_IN, 1'b1);
        try(SDCD_OP_SLP_IN, 1'b0);
        cmp("asleep", 16'h0001, {15'h0, asleep});
        try(SDCD_OP_SLP_OUT, 1'b0);
        cmp("asleep", 16'h0000, {15'h0, asleep});
        all_idle <= 1'b1;
        try(SDCD_OP_RET_IN, 1'b0);
        cmp("retaining", 16'h0001, {15'h0, retaining});
        cmp("termination", 16'h0000, {15'h0, termination_on});
        try(SDCD_OP_RET_OUT, 1'b0);
        cmp("retaining", 16'h0000, {15'h0, retaining});
        try(SDCD_OP_STORE, 1'b1);
        repeat (520) @(negedge mclk);
        send(SDCD_OP_OPEN, 3'h0, 13'h0000);
        expect_op(SDCD_OP_OPEN, 3'h0, 13'h0000);
        send(SDCD_OP_STORE, 3'h0, 13'h1008);
        expect_op(SDCD_OP_STORE, 3'h0, 13'h1008);
        settle();
        stop_test();
    end
endmodule : tb_sdram_command_decoder
